// >>> inc/pekwi_pkg.sv
// Package: register map, field positions and types for the port keypad wake interrupt unit
package pekwi_pkg;

    localparam int          PEKWI_NPINS        = 4;
    localparam logic [31:0] PEKWI_ENABLE_ADDR  = 32'h0000000f * 4;  // Printed offset is an index
    localparam logic [31:0] PEKWI_STATUS_ADDR  = 32'h00000010 * 4;  // Status/control index
    localparam logic [31:0] PEKWI_PINDIR_ADDR  = 32'h00000011 * 4;  // Pin direction index
    localparam logic [31:0] PEKWI_PINDATA_ADDR = 32'h00000012 * 4;  // Pin level index
    localparam logic [15:0] PEKWI_VECTOR_ADDR  = 16'hffec;          // Vector pair low byte
    localparam logic [7:0]  PEKWI_ENABLE_RST   = 8'h00;
    localparam logic [3:0]  PEKWI_DIR_RST      = 4'h0;
    localparam int          PEKWI_PULLUP_LSB   = 4;
    localparam int          PEKWI_FLAG_BIT     = 3;
    localparam int          PEKWI_ACK_BIT      = 2;
    localparam int          PEKWI_MASK_BIT     = 1;
    localparam int          PEKWI_MODE_BIT     = 0;

    // Control bits held by the status/control register
    typedef struct packed {
        logic request_mask;
        logic sense_level_select;
    } pekwi_ctrl_t;

    // Pin side of the block travels together
    typedef struct packed {
        logic [3:0] pin_pullup_select;
        logic [3:0] pin_out_en_n;
    } pekwi_pin_ctrl_t;

endpackage : pekwi_pkg

// >>> hdl/pekwi_top.sv
// Design: four-pin keypad wake interrupt unit with an APB register slave
//
// Operation
// - Enable bits 3:0 pick which pins raise keypad requests.
// - Enabling a pin as a source leaves its pull-up untouched.
// - Enable bits 7:4 switch pin pull-ups on; cleared by reset.
// - Latch request when an enabled pin falls after all were high.
// - Edge mode: a fall is ignored while another enabled pin is low.
// - Level mode: request stays while any enabled pin is low.
// - Level mode: clear needs acknowledge and all pins high, any order.
// - CPU vector fetch of this unit counts as an acknowledge.
// - Writing one to acknowledge bit acknowledges; it reads zero always.
// - Falling edge after an acknowledge latches a fresh request.
// - Unmasked pending request steers the CPU to vector ffec/ffed.
// - Edge mode: fetch or software acknowledge clears request at once.
// - Reset clears request and sense bit even with a pin low.
// - Pending flag shows latched request regardless of mask.
// - Mask bit one blocks request from the CPU; reset clears it.
// - Sense bit one: edge plus low level; zero: falling edge only.
// - Status bits 7:4 read as zero.
// - Enabling a pin as source forces it to input direction.
// - Enable register at index 000f, resets to zero.
module pekwi_top
    import pekwi_pkg::*;
(
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [31:0]             paddr,
    input  wire logic [31:0]             pwdata,
    input  wire logic [3:0]              pstrb,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire logic [3:0]              key_pin_in,
    input  wire logic [3:0]              port_out_data,
    output logic      [3:0]              key_pin_out,
    output logic      [3:0]              key_pin_oe_n,
    output logic      [3:0]              pin_pullup_select,
    input  wire logic                    vector_fetch,
    output logic                         irq_request,
    output logic      [15:0]             irq_vector_addr
);

    // Request tracker states
    typedef enum logic [1:0]
    {
        REQ_IDLE,
        REQ_PENDING,
        REQ_ACKED
    } pekwi_req_state_t;

    logic [7:0]         enable_ff;
    logic [3:0]         pin_direction_ff;
    pekwi_ctrl_t        ctrl_ff;
    pekwi_req_state_t   req_state_ff;
    pekwi_req_state_t   nxt_req_state;
    logic               pending;
    logic [3:0]         sync1_ff;
    logic [3:0]         sync2_ff;
    logic               any_low_prev_ff;
    logic [31:0]        prdata_ff;
    logic               pslverr_ff;
    pekwi_pin_ctrl_t    pin_ctrl;
    logic [3:0]         key_pin_irq_select;
    logic               wr_access;
    logic               rd_access;
    logic               request_acknowledge;
    logic               any_low;
    logic               fall_event;
    logic               ack_any;
    logic               setup_phase;
    logic               level_mode;
    logic [31:0]        nxt_prdata;
    logic               nxt_pslverr;

    // Known register offset test, shared by read and write paths
    function automatic logic addr_known(input logic [31:0] a);
        return (a == PEKWI_ENABLE_ADDR) || (a == PEKWI_STATUS_ADDR) ||
               (a == PEKWI_PINDIR_ADDR) || (a == PEKWI_PINDATA_ADDR);
    endfunction

    // Write strobe for one register
    // Only byte lane 0 carries register data
    function automatic logic reg_write_hit(input logic        wr,
                                           input logic [31:0] a,
                                           input logic [3:0]  strb,
                                           input logic [31:0] target);
        return wr && (a == target) && strb[0];
    endfunction

    // Register map, one byte per word:
    //   enable     7:4 pull-ups, 3:0 sources
    //   status     3 pending flag, read only
    //              2 acknowledge, reads zero
    //              1 request mask
    //              0 level sensing on
    //   direction  3:0, one is an output
    //   pin level  3:0, synchronised, read only
    // Upper 24 bits always read zero.
    // Other addresses: error, no effect.

    // Bus timing: no wait states.
    // Read data is latched at the setup edge
    // and holds until the next read.
    // Writes land at the access edge.

    // Pin timing: a pin low before edge N
    // reaches the detector after N+1 and
    // sets the request at N+2.
    // Pulses under one clock may be missed;
    // key bounce is left to software.

    // Reset state: all registers zero, so
    // no source, no pull-up, all inputs.
    // The synchroniser resets high, like an
    // idle pulled pin, so no false edge.

    // Hazards left to software:
    // enabling a pin whose pad has not risen
    // latches a false request, so mask,
    // make inputs, enable, acknowledge,
    // then unmask.
    // A pull-up hides an open key on reads.

    // Limits: pstrb[0] low ignores a write.
    // Port data lives outside this block;
    // key_pin_out passes port_out_data.
    // The vector address is a constant; the
    // CPU returns a vector_fetch pulse.

    // Zero-wait slave: access phase completes in its first cycle
    assign pready      = 1'b1;
    assign setup_phase = psel && !penable;
    assign wr_access   = psel && penable && pwrite;
    assign rd_access   = setup_phase && !pwrite;

    assign key_pin_irq_select = enable_ff[3:0];
    // Sense select from the control register
    assign level_mode         = ctrl_ff.sense_level_select;

    // Acknowledge is a write strobe only, never stored
    assign request_acknowledge = reg_write_hit(wr_access, paddr, pstrb, PEKWI_STATUS_ADDR)
                                 && pwdata[PEKWI_ACK_BIT];

    // Keys are asynchronous to pclk; two flops
    // cost two cycles but tame metastability.
    // First stage, resets high
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sync1_ff <= 4'hf;
        else
            sync1_ff <= key_pin_in;
    end

    // Second stage feeds detector and reads
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sync2_ff <= 4'hf;
        else
            sync2_ff <= sync1_ff;
    end

    // Detector: any_low ORs the enabled pins.
    // In edge mode only its rise latches, which ignores a
    // second key while the first is held.
    // Changing enables can make such a rise,
    // hence masking while reconfiguring.

    // Only the all-high to some-low transition counts as an edge
    assign any_low    = |(~sync2_ff & key_pin_irq_select);
    assign fall_event = any_low && !any_low_prev_ff;
    // Vector fetch and software write both acknowledge
    assign ack_any    = request_acknowledge || vector_fetch;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            any_low_prev_ff <= 1'b0;
        else
            any_low_prev_ff <= any_low;
    end

    // Request tracker
    //   REQ_IDLE     nothing latched
    //   REQ_PENDING  latched, shown in the flag
    //   REQ_ACKED    level mode: acknowledged,
    //                waiting for pins high
    // An edge beats a same-cycle acknowledge,
    // so no key press is lost.
    // No counters: only acknowledge or reset
    // can end a request.
    always_comb
    begin
        nxt_req_state = req_state_ff;
        case (req_state_ff)
            REQ_IDLE:
            begin
                // Level mode raises the request while a pin is low
                if (level_mode && any_low)
                    nxt_req_state = REQ_PENDING;
            end
            REQ_PENDING:
            begin
                // Edge mode clears at once on acknowledge
                if (ack_any && !level_mode)
                    nxt_req_state = REQ_IDLE;
                // Level mode also needs all pins high
                else if (ack_any && !any_low)
                    nxt_req_state = REQ_IDLE;
                else if (ack_any)
                    nxt_req_state = REQ_ACKED;
            end
            REQ_ACKED:
            begin
                // Back in edge mode the request stays latched
                if (!level_mode && ack_any)
                    nxt_req_state = REQ_IDLE;
                else if (!level_mode)
                    nxt_req_state = REQ_PENDING;
                // Pins high completes the clear, either order
                else if (!any_low)
                    nxt_req_state = REQ_IDLE;
            end
            default:
                nxt_req_state = REQ_IDLE;
        endcase
        // Latch on falling edge; a later edge re-arms
        if (fall_event)
            nxt_req_state = REQ_PENDING;
    end

    // Reset drops the request even with a pin held low
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            req_state_ff <= REQ_IDLE;
        else
            req_state_ff <= nxt_req_state;
    end
    assign pending = (req_state_ff != REQ_IDLE);

    // Enable register write; pull-up half resets to zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            enable_ff <= PEKWI_ENABLE_RST;
        else if (reg_write_hit(wr_access, paddr, pstrb, PEKWI_ENABLE_ADDR))
            enable_ff <= pwdata[7:0];
    end

    // Sense and mask bits, both cleared by reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_ff <= '0;
        else if (reg_write_hit(wr_access, paddr, pstrb, PEKWI_STATUS_ADDR))
        begin
            ctrl_ff.request_mask       <= pwdata[PEKWI_MASK_BIT];
            ctrl_ff.sense_level_select <= pwdata[PEKWI_MODE_BIT];
        end
    end

    // Port direction bits live here so the override can be applied
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pin_direction_ff <= PEKWI_DIR_RST;
        else if (reg_write_hit(wr_access, paddr, pstrb, PEKWI_PINDIR_ADDR))
            pin_direction_ff <= pwdata[3:0];
    end

    // A source pin is always an input, so a key
    // never fights the port driver; the kept
    // direction bit returns when disabled.
    // Enabled source pins never drive, whatever the direction bit
    // Pull-ups come only from the upper enable bits
    always_comb
    begin
        pin_ctrl.pin_out_en_n      = ~(pin_direction_ff & ~key_pin_irq_select);
        pin_ctrl.pin_pullup_select = enable_ff[7:4];
    end
    assign key_pin_oe_n      = pin_ctrl.pin_out_en_n;
    assign pin_pullup_select = pin_ctrl.pin_pullup_select;
    assign key_pin_out       = port_out_data;

    // Mask gates the CPU request; fixed vector address
    assign irq_request     = pending && !ctrl_ff.request_mask;

    // Vector location is fixed for this unit
    assign irq_vector_addr = PEKWI_VECTOR_ADDR;

    // Read data captured in setup so it is stable through the access phase
    always_comb
    begin
        nxt_prdata = prdata_ff;
        if (rd_access)
        begin
            nxt_prdata = 32'h00000000;
            if (paddr == PEKWI_ENABLE_ADDR)
                nxt_prdata[7:0] = enable_ff;
            // Upper status bits and acknowledge read zero
            else if (paddr == PEKWI_STATUS_ADDR)
            begin
                nxt_prdata[PEKWI_FLAG_BIT] = pending;
                nxt_prdata[PEKWI_MASK_BIT] = ctrl_ff.request_mask;
                nxt_prdata[PEKWI_MODE_BIT] = ctrl_ff.sense_level_select;
            end
            else if (paddr == PEKWI_PINDIR_ADDR)
                nxt_prdata[3:0] = pin_direction_ff;
            else if (paddr == PEKWI_PINDATA_ADDR)
                nxt_prdata[3:0] = sync2_ff;
        end
    end

    // Error decided in setup and held over the access edge,
    // where the master samples it
    always_comb
    begin
        nxt_pslverr = 1'b0;
        if (setup_phase)
            nxt_pslverr = !addr_known(paddr);
        else if (psel && penable)
            nxt_pslverr = pslverr_ff;
    end

    // Read data register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_ff <= 32'h00000000;
        else
            prdata_ff <= nxt_prdata;
    end

    // Error register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pslverr_ff <= 1'b0;
        else
            pslverr_ff <= nxt_pslverr;
    end

    assign prdata  = prdata_ff;
    assign pslverr = pslverr_ff && psel && penable;  // Unmapped address: error, no effect

endmodule // pekwi_top

// >>> verif/pekwi_monitor.sv
// Checker: port-level properties of the keypad wake interrupt unit
module pekwi_monitor
    import pekwi_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic [3:0]  key_pin_in,
    input wire logic [3:0]  key_pin_oe_n,
    input wire logic [3:0]  pin_pullup_select,
    input wire logic        vector_fetch,
    input wire logic        irq_request,
    input wire logic [15:0] irq_vector_addr
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] en_ff;
    logic [1:0] cm_ff;
    wire logic  wr   = psel && penable && pwrite && pstrb[0];
    wire logic  ackw = wr && paddr == PEKWI_STATUS_ADDR && pwdata[PEKWI_ACK_BIT];
    // Own copy of the writable bits, since the design keeps its copy hidden
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            en_ff <= 8'h00;
            cm_ff <= 2'h0;
        end
        else if (wr && paddr == PEKWI_ENABLE_ADDR)
            en_ff <= pwdata[7:0];
        else if (wr && paddr == PEKWI_STATUS_ADDR)
            cm_ff <= pwdata[1:0];
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Fall from all-high on enabled pins, then three calm cycles for the two-flop delay
    sequence s_fall; &(key_pin_in | ~en_ff[3:0]) ##1 |(~key_pin_in & en_ff[3:0]); endsequence
    sequence s_calm; (!cm_ff[1] && !psel && !vector_fetch)[*3]; endsequence
    property p_latch; s_fall ##0 s_calm |=> irq_request; endproperty
    a_latch: assert property (p_latch) else $error("fall did not raise request");
    property p_hold; (cm_ff[0] && !psel && |(en_ff[3:0] & ~key_pin_in))[*3] ##0 irq_request |=> irq_request; endproperty
    a_hold: assert property (p_hold) else $error("level request dropped early");
    property p_eclr; !cm_ff[0] && (ackw || vector_fetch) |=> !irq_request; endproperty
    a_eclr: assert property (p_eclr) else $error("edge request not cleared");
    property p_mask; cm_ff[1] |-> !irq_request; endproperty
    a_mask: assert property (p_mask) else $error("masked request reached cpu");
    property p_pull; wr && paddr == PEKWI_ENABLE_ADDR |=> pin_pullup_select == $past(pwdata[7:4]); endproperty
    a_pull: assert property (p_pull) else $error("pull-up select wrong");
    property p_input; (~key_pin_oe_n & en_ff[3:0]) == 4'h0; endproperty
    a_input: assert property (p_input) else $error("enabled pin driven");
    property p_rdz; psel && penable && !pwrite && paddr == PEKWI_STATUS_ADDR |-> prdata[7:4] == 4'h0 && !prdata[2];
    endproperty
    a_rdz: assert property (p_rdz) else $error("status zero bits set");
    property p_flag; psel && !penable && !pwrite && paddr == PEKWI_STATUS_ADDR && irq_request |=> prdata[3];
    endproperty
    a_flag: assert property (p_flag) else $error("flag missing");
    property p_rst; $rose(presetn) |-> !irq_request; endproperty
    a_rst: assert property (p_rst) else $error("request after reset");
    property p_vec; irq_vector_addr == PEKWI_VECTOR_ADDR; endproperty
    a_vec: assert property (p_vec) else $error("vector address wrong");
endmodule // pekwi_monitor

bind pekwi_top pekwi_monitor pekwi_monitor_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .key_pin_in, .key_pin_oe_n, .pin_pullup_select, .vector_fetch, .irq_request, .irq_vector_addr);

// >>> verif/pekwi_keys.sv
// Partner: key switches and pads on the four keypad pins
module pekwi_keys
(
    input  wire logic       pclk,
    input  wire logic [3:0] press,
    input  wire logic [3:0] pull_en,
    input  wire logic [3:0] oe_n,
    input  wire logic [3:0] drive,
    output logic      [3:0] level
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] noise_ff = 4'h5;
    // A floating pad wanders, so an unpulled pin toggles every clock and never holds high
    always_ff @(posedge pclk)
        noise_ff <= ~noise_ff;
    always_comb
        for (int i = 0; i < 4; i++)
            level[i] = !oe_n[i] ? drive[i] : press[i] ? 1'b0 : pull_en[i] ? 1'b1 : noise_ff[i];
endmodule // pekwi_keys

// >>> verif/pekwi_top_tb.sv
// Testbench: registers, key scenarios and reset of the keypad wake interrupt unit
module pekwi_top_tb
    import pekwi_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        pclk, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        vector_fetch = 1'b0, pready, pslverr, irq_request, irq_raw, err;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
    logic [7:0]  v;
    logic [3:0]  press = 4'h0, port_out = 4'h0, level, drive, oe_n, pull;
    int          fail_count = 0, total_checks = 0, cyc = 0;
    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    pekwi_top pekwi_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hf), .prdata,
        .pready, .pslverr, .key_pin_in(level), .port_out_data(port_out), .key_pin_out(drive), .key_pin_oe_n(oe_n),
        .pin_pullup_select(pull), .vector_fetch, .irq_request(irq_raw), .irq_vector_addr());
    pekwi_keys pekwi_keys_inst (.pclk, .press, .pull_en(pull), .oe_n, .drive, .level);
    // Request copied at the falling edge, so checks never race the launching edge
    always @(negedge pclk)
        irq_request <= irq_raw;
    // One bus transfer; the request is held until pready is seen
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_reg({31'h0, got}, {31'h0, exp});
    endtask
    function automatic logic [31:0] exp_st(input logic f, input logic m, input logic s);
        return {28'h0, f, 1'b0, m, s};
    endfunction
    // Waits a bounded time for the request line, then compares it
    task automatic wait_irq(input logic e);
        repeat (8)
            if (irq_request !== e)
                @(posedge pclk);
        chk_bit(irq_request, e);
    endtask
    task automatic fetch;
        vector_fetch <= 1'b1;
        @(posedge pclk);
        vector_fetch <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Hang guard: the run needs under 1500 cycles
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            fail_count++;
            tally_and_finish();
        end
    end
    initial
    begin
        void'($urandom(65));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, PEKWI_ENABLE_ADDR, 32'h0);
        chk_reg(rd, 32'h0);
        apb(1'b0, 32'h100, 32'h0);
        chk_bit(err, 1'b1);
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b1, PEKWI_STATUS_ADDR, 32'(i) | 32'h4);
            apb(1'b0, PEKWI_STATUS_ADDR, 32'h0);
            chk_reg(rd, exp_st(1'b0, i[1], i[0]));
        end
        // Random enables with all pins set as outputs; enabled pins stay pulled up
        apb(1'b1, PEKWI_PINDIR_ADDR, 32'hf);
        repeat (6)
        begin
            v = 8'($urandom);
            v[3:0] = v[3:0] & v[7:4];
            port_out <= 4'($urandom);
            apb(1'b1, PEKWI_ENABLE_ADDR, {24'h0, v});
            apb(1'b0, PEKWI_ENABLE_ADDR, 32'h0);
            chk_reg(rd, {24'h0, v});
            chk_reg({28'h0, pull}, {28'h0, v[7:4]});
            chk_reg({28'h0, oe_n}, {28'h0, v[3:0]});
        end
        apb(1'b1, PEKWI_STATUS_ADDR, 32'h2);
        apb(1'b1, PEKWI_PINDIR_ADDR, 32'h0);
        apb(1'b1, PEKWI_ENABLE_ADDR, 32'hff);
        apb(1'b1, PEKWI_STATUS_ADDR, 32'h6);
        apb(1'b1, PEKWI_STATUS_ADDR, 32'h0);
        for (int i = 0; i < 4; i++)
        begin
            press <= 4'h1 << i;
            wait_irq(1'b1);
            apb(1'b0, PEKWI_STATUS_ADDR, 32'h0);
            chk_reg(rd, exp_st(1'b1, 1'b0, 1'b0));
            apb(1'b1, PEKWI_STATUS_ADDR, 32'h4);
            chk_bit(irq_request, 1'b0);
            press <= press | 4'(4'h1 << ((i + 1) % 4));
            repeat (6) @(posedge pclk);
            chk_bit(irq_request, 1'b0);
            press <= 4'h0;
            repeat (4) @(posedge pclk);
        end
        // Masked request still shows in the flag and is taken by a vector fetch
        apb(1'b1, PEKWI_STATUS_ADDR, 32'h2);
        press <= 4'h1 << ($urandom % 4);
        repeat (6) @(posedge pclk);
        chk_bit(irq_request, 1'b0);
        apb(1'b0, PEKWI_STATUS_ADDR, 32'h0);
        chk_reg(rd, exp_st(1'b1, 1'b1, 1'b0));
        fetch();
        apb(1'b0, PEKWI_STATUS_ADDR, 32'h0);
        chk_reg(rd, exp_st(1'b0, 1'b1, 1'b0));
        press <= 4'h0;
        apb(1'b1, PEKWI_STATUS_ADDR, 32'h1);
        press <= 4'h2;
        wait_irq(1'b1);
        apb(1'b1, PEKWI_STATUS_ADDR, 32'h5);
        repeat (4) @(posedge pclk);
        chk_bit(irq_request, 1'b1);
        press <= 4'h0;
        wait_irq(1'b0);
        press <= 4'h4;
        wait_irq(1'b1);
        press <= 4'h0;
        repeat (6) @(posedge pclk);
        chk_bit(irq_request, 1'b1);
        fetch();
        wait_irq(1'b0);
        // Reset in mid-run with a key still held
        press <= 4'h8;
        wait_irq(1'b1);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, PEKWI_STATUS_ADDR, 32'h0);
        chk_reg(rd, 32'h0);
        // Pull-ups off and pins inputs after reset, so the held key reads low
        apb(1'b0, PEKWI_PINDATA_ADDR, 32'h0);
        chk_bit(rd[3], 1'b0);
        tally_and_finish();
    end
endmodule // pekwi_top_tb
